// >>> core/pcma_pkg.sv
// Shared constants and types for the port command memory access block.
package pcma_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int CMD_WORDS = 4;

  // ==========================================================================
  // Command codes (plain values; zero is the null command)
  // ==========================================================================
  localparam logic [15:0] CMD_NULL = 16'h0000;
  localparam logic [15:0] CMD_INTERNAL_READ = 16'h0001;
  localparam logic [15:0] CMD_INTERNAL_WRITE = 16'h0002;
  localparam logic [15:0] CMD_EXTENDED_READ = 16'h0003;
  localparam logic [15:0] CMD_EXTENDED_WRITE = 16'h0004;
  localparam logic [15:0] CMD_TRANSPORT_CONFIG = 16'h0005;

  // Arbitrary value chosen for the acknowledge response word.
  localparam logic [15:0] ACKNOWLEDGE_RESPONSE = 16'h0fed;

  // ==========================================================================
  // Command structure word positions
  // ==========================================================================
  localparam logic [1:0] POS_CODE = 2'h0;
  localparam logic [1:0] POS_ADDR = 2'h1;
  localparam logic [1:0] POS_LEN = 2'h2;
  localparam logic [1:0] POS_AUX = 2'h3;

  // ==========================================================================
  // Write merge selector values, baud reset value and address step
  // ==========================================================================
  localparam logic [15:0] MERGE_DIRECT = 16'h0000;
  localparam logic [15:0] MERGE_AND = 16'h0001;
  localparam logic [15:0] MERGE_OR = 16'h0002;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ==========================================================================
  // Host timing obligations (kept for the verification side)
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int CMD_GAP_NS = 30000;
  localparam int BAUD_GAP_NS = 100000;
  localparam int CMD_GAP_CYC = (CMD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BAUD_GAP_CYC = (BAUD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PCMA_HIGH_SPEED_SERIAL_PORT = 2'h0,
    PCMA_SPI_PORT = 2'h1,
    PCMA_PARALLEL_HOST_PORT = 2'h2
  } pcma_transport_e;

  typedef enum logic [10:0] {
    S_FETCH    = 11'b000_0000_0001,
    S_DISPATCH = 11'b000_0000_0010,
    S_RD_ADDR  = 11'b000_0000_0100,
    S_RD_PUSH  = 11'b000_0000_1000,
    S_IW_RECV  = 11'b000_0001_0000,
    S_IW_APPLY = 11'b000_0010_0000,
    S_XR_BUS   = 11'b000_0100_0000,
    S_XW_RECV  = 11'b000_1000_0000,
    S_XW_RD    = 11'b001_0000_0000,
    S_XW_BUS   = 11'b010_0000_0000,
    S_ACK      = 11'b100_0000_0000
  } pcma_state_e;

endpackage

// >>> core/pcma_core.sv
// Command interpreter that serves memory and configuration commands from a serial host port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RL1] Merge selector: 0 stores word, 1 stores AND with memory, 2 stores OR.
// [RL2] Internal read works only on serial transports; returns length words from address.
// [RL3] Parallel port reaches memory directly, so memory commands there only acknowledge.
// [RL4] Internal reads and writes never check address range; address simply wraps.
// [RL5] Internal write stores length received words from address, internal memory only.
// [RL6] Extended read copies from any address into staging buffer, then sends it.
// [RL7] Extended write receives into staging buffer, then copies to any address.
// [RL8] Host gives nonzero count and internal staging pointer for extended commands.
// [RL9] Config loads baud on high-speed serial; other transports just acknowledge.
// [RL10] Host leaves at least 30 us before each new command packet.
// [RL11] Host waits 100 us after a baud change and then uses the new rate.
// [RL12] Command code zero is ignored and gets no response at all.
// [RL13] Code, address, length and auxiliary field arrive as one four-word packet.
// [RL14] Merge selector of zero means a direct write.
// [RL15] One acknowledge word follows each completed command; host waits for it.
module pcma_core #(
  parameter int IMEM_AW = 13
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire pcma_pkg::pcma_transport_e TRANSPORT_SEL,
  input wire logic RX_VALID,
  input wire logic [pcma_pkg::WORD_W-1:0] RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [pcma_pkg::WORD_W-1:0] TX_DATA,
  input wire logic TX_READY,
  output logic XMEM_REQ,
  output logic XMEM_WE,
  output logic [pcma_pkg::ADDR_W-1:0] XMEM_ADDR,
  output logic [pcma_pkg::WORD_W-1:0] XMEM_WDATA,
  input wire logic [pcma_pkg::WORD_W-1:0] XMEM_RDATA,
  input wire logic XMEM_ACK,
  output logic [pcma_pkg::WORD_W-1:0] BAUD_SETTING,
  output logic BAUD_LOAD,
  output logic BUSY
);
  import pcma_pkg::*;

  // ==========================================================================
  // Command state
  // ==========================================================================
  pcma_state_e state_reg, state_next;
  logic [1:0] idx_reg, idx_next;
  logic [15:0] command_code_field_reg, command_code_field_next;
  logic [15:0] target_address_field_reg, target_address_field_next;
  logic [15:0] word_count_field_reg, word_count_field_next;
  logic [15:0] aux_field_reg, aux_field_next;
  logic [15:0] ptr_reg, ptr_next;
  logic [15:0] sptr_reg, sptr_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] word_reg, word_next;
  logic [15:0] baud_reg, baud_next;
  logic baud_load_reg, baud_load_next;

  // Memory port and transmit buffer feed, computed with the next state.
  logic mem_we;
  logic [IMEM_AW-1:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata_reg;
  logic push_valid;
  logic [15:0] push_data;
  logic push_ready;

  logic serial_port;
  logic last_word;
  assign serial_port = (TRANSPORT_SEL != PCMA_PARALLEL_HOST_PORT);
  assign last_word = (cnt_reg == 16'h0001);

  function automatic logic [15:0] merge(input logic [15:0] sel, input logic [15:0] cur,
                                        input logic [15:0] din);
    logic [15:0] r;
    r = din; // RL14
    if (sel == MERGE_AND) begin
      r = cur & din; // RL1
    end else if (sel == MERGE_OR) begin
      r = cur | din; // RL1
    end
    return r;
  endfunction

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    command_code_field_next = command_code_field_reg;
    target_address_field_next = target_address_field_reg;
    word_count_field_next = word_count_field_reg;
    aux_field_next = aux_field_reg;
    ptr_next = ptr_reg;
    sptr_next = sptr_reg;
    cnt_next = cnt_reg;
    word_next = word_reg;
    baud_next = baud_reg;
    baud_load_next = 1'b0;
    mem_we = 1'b0;
    mem_addr = ptr_reg[IMEM_AW:1]; // RL4
    mem_wdata = RX_DATA;
    push_valid = 1'b0;
    push_data = ACKNOWLEDGE_RESPONSE;
    RX_READY = 1'b0;
    XMEM_REQ = 1'b0;
    XMEM_WE = 1'b0;
    unique case (state_reg)
      S_FETCH: begin
        RX_READY = CLK_EN;
        if (RX_VALID) begin
          unique case (idx_reg) // RL13
            POS_CODE: command_code_field_next = RX_DATA;
            POS_ADDR: target_address_field_next = RX_DATA;
            POS_LEN: word_count_field_next = RX_DATA;
            POS_AUX: aux_field_next = RX_DATA;
          endcase
          idx_next = idx_reg + 2'h1;
          if (idx_reg == POS_AUX) begin
            state_next = S_DISPATCH;
          end
        end
      end
      S_DISPATCH: begin
        ptr_next = target_address_field_reg;
        sptr_next = aux_field_reg;
        cnt_next = word_count_field_reg;
        state_next = S_ACK;
        if (command_code_field_reg == CMD_NULL) begin
          state_next = S_FETCH; // RL12
        end else if (command_code_field_reg == CMD_TRANSPORT_CONFIG) begin
          if (TRANSPORT_SEL == PCMA_HIGH_SPEED_SERIAL_PORT) begin
            baud_next = target_address_field_reg; // RL9
            baud_load_next = 1'b1;
          end
        end else if (word_count_field_reg == 16'h0000 || !serial_port) begin
          state_next = S_ACK; // RL3
        end else if (command_code_field_reg == CMD_INTERNAL_READ) begin
          state_next = S_RD_ADDR; // RL2
        end else if (command_code_field_reg == CMD_INTERNAL_WRITE) begin
          state_next = S_IW_RECV; // RL5
        end else if (command_code_field_reg == CMD_EXTENDED_READ) begin
          state_next = S_XR_BUS; // RL6
        end else if (command_code_field_reg == CMD_EXTENDED_WRITE) begin
          ptr_next = aux_field_reg; // RL7
          sptr_next = target_address_field_reg;
          state_next = S_XW_RECV;
        end
      end
      S_RD_ADDR: begin
        state_next = S_RD_PUSH;
      end
      S_RD_PUSH: begin
        push_valid = 1'b1;
        push_data = mem_rdata_reg;
        if (push_ready) begin
          ptr_next = ptr_reg + WORD_STEP;
          cnt_next = cnt_reg - 16'h0001;
          state_next = last_word ? S_ACK : S_RD_ADDR; // RL2
        end
      end
      S_IW_RECV: begin
        RX_READY = CLK_EN;
        if (RX_VALID) begin
          word_next = RX_DATA;
          state_next = S_IW_APPLY;
        end
      end
      S_IW_APPLY: begin
        mem_we = 1'b1;
        mem_wdata = merge(aux_field_reg, mem_rdata_reg, word_reg); // RL1
        ptr_next = ptr_reg + WORD_STEP;
        cnt_next = cnt_reg - 16'h0001;
        state_next = last_word ? S_ACK : S_IW_RECV; // RL5
      end
      S_XR_BUS: begin
        XMEM_REQ = 1'b1;
        mem_addr = sptr_reg[IMEM_AW:1]; // RL8
        mem_wdata = XMEM_RDATA;
        if (XMEM_ACK) begin
          mem_we = 1'b1; // RL6
          ptr_next = ptr_reg + WORD_STEP;
          sptr_next = sptr_reg + WORD_STEP;
          cnt_next = cnt_reg - 16'h0001;
          if (last_word) begin
            ptr_next = aux_field_reg;
            cnt_next = word_count_field_reg;
            state_next = S_RD_ADDR; // RL6
          end
        end
      end
      S_XW_RECV: begin
        RX_READY = CLK_EN;
        if (RX_VALID) begin
          mem_we = 1'b1; // RL7
          ptr_next = ptr_reg + WORD_STEP;
          cnt_next = cnt_reg - 16'h0001;
          if (last_word) begin
            ptr_next = aux_field_reg;
            cnt_next = word_count_field_reg;
            state_next = S_XW_RD;
          end
        end
      end
      S_XW_RD: begin
        state_next = S_XW_BUS;
      end
      S_XW_BUS: begin
        XMEM_REQ = 1'b1;
        XMEM_WE = 1'b1;
        if (XMEM_ACK) begin
          ptr_next = ptr_reg + WORD_STEP;
          sptr_next = sptr_reg + WORD_STEP;
          cnt_next = cnt_reg - 16'h0001;
          state_next = last_word ? S_ACK : S_XW_RD; // RL7
        end
      end
      S_ACK: begin
        push_valid = 1'b1; // RL15
        if (push_ready) begin
          idx_next = POS_CODE;
          state_next = S_FETCH;
        end
      end
    endcase
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_reg <= S_FETCH;
      idx_reg <= POS_CODE;
      command_code_field_reg <= CMD_NULL;
      target_address_field_reg <= 16'h0000;
      word_count_field_reg <= 16'h0000;
      aux_field_reg <= MERGE_DIRECT;
      ptr_reg <= 16'h0000;
      sptr_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      word_reg <= 16'h0000;
      baud_reg <= BAUD_RESET;
      baud_load_reg <= 1'b0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      command_code_field_reg <= command_code_field_next;
      target_address_field_reg <= target_address_field_next;
      word_count_field_reg <= word_count_field_next;
      aux_field_reg <= aux_field_next;
      ptr_reg <= ptr_next;
      sptr_reg <= sptr_next;
      cnt_reg <= cnt_next;
      word_reg <= word_next;
      baud_reg <= baud_next;
      baud_load_reg <= baud_load_next;
    end
  end

  // ==========================================================================
  // Internal memory, also the staging buffer
  // ==========================================================================
  // Single port with a registered read: merges and copies spend one cycle
  // presenting the address so the read word is stable when it is used.
  logic [15:0] imem [0:(1<<IMEM_AW)-1];

  always_ff @(posedge REF_CLK) begin
    if (CLK_EN) begin
      if (mem_we) begin
        imem[mem_addr] <= mem_wdata;
      end
      mem_rdata_reg <= imem[mem_addr];
    end
  end

  assign XMEM_ADDR = (state_reg == S_XW_BUS) ? sptr_reg : ptr_reg;
  assign XMEM_WDATA = mem_rdata_reg;
  assign BAUD_SETTING = baud_reg;
  assign BAUD_LOAD = baud_load_reg;
  assign BUSY = (state_reg != S_FETCH);

  // ==========================================================================
  // Two-entry transmit buffer
  // ==========================================================================
  // A stall on TX_READY holds the command engine instead of dropping words.
  logic [15:0] buf0_reg, buf0_next;
  logic [15:0] buf1_reg, buf1_next;
  logic [1:0] fill_reg, fill_next;
  logic do_push;
  logic do_pop;

  assign push_ready = (fill_reg != 2'h2) && CLK_EN;
  assign do_push = push_valid && push_ready;
  assign do_pop = TX_VALID && TX_READY && CLK_EN;
  assign TX_VALID = (fill_reg != 2'h0);
  assign TX_DATA = buf0_reg;

  always_comb begin
    buf0_next = buf0_reg;
    buf1_next = buf1_reg;
    fill_next = fill_reg;
    if (do_pop) begin
      buf0_next = buf1_reg;
      fill_next = fill_next - 2'h1;
    end
    if (do_push) begin
      if (fill_next == 2'h0) begin
        buf0_next = push_data;
      end else begin
        buf1_next = push_data;
      end
      fill_next = fill_next + 2'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      buf0_reg <= 16'h0000;
      buf1_reg <= 16'h0000;
      fill_reg <= 2'h0;
    end else if (CLK_EN) begin
      buf0_reg <= buf0_next;
      buf1_reg <= buf1_next;
      fill_reg <= fill_next;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/pcma_core_asserts.sv
// Port-level checks on the command interpreter.
`timescale 1ns/1ps
`default_nettype none
module pcma_core_chk
  import pcma_pkg::*;
#(
  parameter int IMEM_AW = 13
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire pcma_pkg::pcma_transport_e TRANSPORT_SEL,
  input wire logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [15:0] TX_DATA,
  input wire logic TX_READY,
  input wire logic XMEM_REQ,
  input wire logic XMEM_WE,
  input wire logic [15:0] XMEM_ADDR,
  input wire logic XMEM_ACK,
  input wire logic [15:0] BAUD_SETTING,
  input wire logic BAUD_LOAD,
  input wire logic BUSY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  AST_RESET_IDLE: assert property (disable iff (1'b0) !RESET_N && CLK_EN |=>
    !TX_VALID && !XMEM_REQ && !BAUD_LOAD && BAUD_SETTING == 16'h0000)
    else $error("outputs not idle after reset");
  AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("response word dropped or changed while stalled");
  AST_XMEM_HOLD: assert property (XMEM_REQ && !XMEM_ACK |=>
    XMEM_REQ && $stable(XMEM_ADDR) && $stable(XMEM_WE))
    else $error("memory request changed before acknowledge");
  AST_BAUD_PULSE: assert property (BAUD_LOAD |=> !BAUD_LOAD)
    else $error("baud load longer than one cycle");
  AST_BAUD_HSS: assert property (BAUD_LOAD |-> TRANSPORT_SEL == PCMA_HIGH_SPEED_SERIAL_PORT)
    else $error("baud loaded on a transport without baud setting");
  AST_BAUD_CAUSE: assert property (!BAUD_LOAD |-> $stable(BAUD_SETTING))
    else $error("baud setting changed without load pulse");
  AST_BAUD_ACK: assert property (BAUD_LOAD |-> ##[0:3] TX_VALID)
    else $error("no acknowledge after baud change");
  AST_PARALLEL_NO_XMEM: assert property (TRANSPORT_SEL == PCMA_PARALLEL_HOST_PORT |-> !XMEM_REQ)
    else $error("memory access on parallel transport");
  AST_READY_EXCL: assert property (RX_READY |-> !XMEM_REQ)
    else $error("command words taken during memory access");
  AST_IDLE_READY: assert property (!BUSY && CLK_EN |-> RX_READY)
    else $error("idle but not accepting command words");
  AST_FREEZE: assert property (!CLK_EN |-> !RX_READY)
    else $error("words accepted while clock disabled");
  COV_BAUD: cover property (BAUD_LOAD);
  COV_XWRITE: cover property (XMEM_REQ && XMEM_WE && XMEM_ACK);
  COV_ACK: cover property (TX_VALID && TX_READY && TX_DATA == ACKNOWLEDGE_RESPONSE);
endmodule
bind pcma_core pcma_core_chk #(.IMEM_AW(IMEM_AW)) u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .CLK_EN(CLK_EN), .TRANSPORT_SEL(TRANSPORT_SEL), .RX_READY(RX_READY), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_READY(TX_READY), .XMEM_REQ(XMEM_REQ), .XMEM_WE(XMEM_WE),
  .XMEM_ADDR(XMEM_ADDR), .XMEM_ACK(XMEM_ACK), .BAUD_SETTING(BAUD_SETTING),
  .BAUD_LOAD(BAUD_LOAD), .BUSY(BUSY));
`default_nettype wire

// >>> testbench/pcma_host_model.sv
// Host processor model: sends command words and collects response words.
`timescale 1ns/1ps
`default_nettype none
module pcma_host_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [15:0] rx_data,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  output logic tx_ready
);
  logic [15:0] got [$];
  logic [3:0] cnt = 4'h0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 16'h0000;
    tx_ready = 1'b1;
  end
  // Ready is combinational, so it is judged at the falling edge to avoid a race.
  task automatic send(input logic [15:0] w);
    rx_valid = 1'b1;
    rx_data = w;
    @(negedge clk);
    while (rx_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    #1;
  endtask
  // A released line shows the inverse of its last word, so stale data cannot pass.
  task automatic idle();
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
  always @(negedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  always @(posedge clk) begin
    #1;
    cnt = cnt + 4'h1;
    tx_ready = !stall || cnt[1];
  end
endmodule
`default_nettype wire

// >>> testbench/tb_pcma_core.sv
// Self-checking bench for the command interpreter.
`timescale 1ns/1ps
`default_nettype none
module tb_pcma_core;
  import pcma_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  pcma_transport_e tsel = PCMA_HIGH_SPEED_SERIAL_PORT;
  logic stall = 1'b0;
  logic xack = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, xreq, xwe, bload, busy;
  logic [15:0] rx_data, tx_data, xaddr, xwdata, baud;
  logic [15:0] xrdata = 16'h0000;
  logic [15:0] xm [0:32767];
  logic [15:0] xr [0:32767];
  logic [15:0] im [0:8191];
  logic [15:0] dq [$];
  logic [15:0] baud_exp = 16'h0000;
  logic [31:0] seed = 32'h19b0dcb9;
  int xwait = 0;
  int errors = 0;
  int cmp_count = 0;
  int loads = 0;
  int loads_exp = 0;
  always #5 clk = ~clk;
  // Every baud load pulse is counted, so a missing or extra pulse shows up.
  always @(negedge clk) begin
    if (bload) loads++;
  end
  pcma_core u_dut (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .TRANSPORT_SEL(tsel),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rx_ready), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .XMEM_REQ(xreq), .XMEM_WE(xwe), .XMEM_ADDR(xaddr),
    .XMEM_WDATA(xwdata), .XMEM_RDATA(xrdata), .XMEM_ACK(xack), .BAUD_SETTING(baud),
    .BAUD_LOAD(bload), .BUSY(busy));
  pcma_host_model u_host (.clk(clk), .stall(stall), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // Far memory answers after a wait of seed[1:0] cycles (none on the first access) and rests one cycle after each access.
  always @(posedge clk) begin
    #1;
    if (xack) begin
      xack = 1'b0;
      xrdata = ~xrdata;
    end else if (xreq && xwait > 0) begin
      xwait--;
    end else if (xreq) begin
      xack = 1'b1;
      xwait = seed[1:0];
      if (xwe) xm[xaddr[15:1]] = xwdata;
      xrdata = xm[xaddr[15:1]];
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run(input logic [15:0] c, a, n, x);
    logic [15:0] e [$];
    logic [15:0] s;
    logic [15:0] w;
    bit mem;
    int i;
    mem = tsel != PCMA_PARALLEL_HOST_PORT;
    u_host.got = {};
    u_host.send(c);
    u_host.send(a);
    u_host.send(n);
    u_host.send(x);
    for (i = 0; i < n && mem; i++) begin
      s = a + 16'(2 * i);
      w = x + 16'(2 * i);
      if (c == CMD_INTERNAL_READ) e.push_back(im[s[13:1]]);
      if (c == CMD_INTERNAL_WRITE || c == CMD_EXTENDED_WRITE) u_host.send(dq[i]);
      if (c == CMD_INTERNAL_WRITE) im[s[13:1]] = x == MERGE_AND ? im[s[13:1]] & dq[i] :
        x == MERGE_OR ? im[s[13:1]] | dq[i] : dq[i];
      if (c == CMD_EXTENDED_WRITE) begin
        im[w[13:1]] = dq[i];
        xr[s[15:1]] = dq[i];
      end
      if (c == CMD_EXTENDED_READ) begin
        im[w[13:1]] = xr[s[15:1]];
        e.push_back(xr[s[15:1]]);
      end
    end
    u_host.idle();
    if (c == CMD_TRANSPORT_CONFIG && tsel == PCMA_HIGH_SPEED_SERIAL_PORT) begin
      baud_exp = a;
      loads_exp++;
    end
    if (c != CMD_NULL) e.push_back(ACKNOWLEDGE_RESPONSE);
    i = 0;
    while (u_host.got.size() < e.size() && i < 2000) begin
      @(posedge clk);
      i++;
    end
    repeat (40) @(posedge clk);
    chk("count", 16'(e.size()), 16'(u_host.got.size()));
    foreach (e[k]) chk("word", e[k], u_host.got[k]);
    chk("baud", baud_exp, baud);
    chk("loads", 16'(loads_exp), 16'(loads));
    repeat (c == CMD_TRANSPORT_CONFIG ? BAUD_GAP_CYC : CMD_GAP_CYC) @(posedge clk);
    #1;
  endtask
  task automatic fill(input int k);
    dq = {};
    repeat (k) begin
      seed = lfsr(seed);
      dq.push_back(seed[15:0]);
    end
  endtask
  initial begin
    for (int i = 0; i < 32768; i++) begin
      xm[i] = 16'(i * 3) ^ 16'h5a5a;
      xr[i] = xm[i];
    end
    repeat (4) @(posedge clk);
    #1;
    chk("baud_rst", 16'h0000, baud);
    chk("busy_rst", 16'h0000, {15'h0000, busy});
    chk("txv_rst", 16'h0000, {15'h0000, tx_valid});
    rst_n = 1'b1;
    for (int m = 0; m < 3; m++) begin
      fill(4);
      stall = m[0];
      run(CMD_INTERNAL_WRITE, 16'h0040, 16'h0004, 16'(m));
      run(CMD_INTERNAL_READ, 16'h0040, 16'h0004, 16'h0000);
    end
    fill(1);
    run(CMD_INTERNAL_WRITE, 16'h4046, 16'h0001, 16'h0000);
    run(CMD_INTERNAL_READ, 16'h0046, 16'h0001, 16'h0000);
    fill(3);
    stall = 1'b1;
    run(CMD_EXTENDED_WRITE, 16'ha000, 16'h0003, 16'h0100);
    for (int k = 0; k < 3; k++) chk("xmem", xr[16'h5000 + k], xm[16'h5000 + k]);
    run(CMD_EXTENDED_READ, 16'ha000, 16'h0003, 16'h0200);
    run(CMD_INTERNAL_READ, 16'h0200, 16'h0003, 16'h0000);
    stall = 1'b0;
    run(16'h0007, 16'h0040, 16'h0001, 16'h0000);
    run(CMD_INTERNAL_READ, 16'h0040, 16'h0000, 16'h0000);
    run(CMD_TRANSPORT_CONFIG, 16'h1234, 16'h0000, 16'h0000);
    tsel = PCMA_SPI_PORT;
    run(CMD_TRANSPORT_CONFIG, 16'h5678, 16'h0000, 16'h0000);
    run(CMD_INTERNAL_READ, 16'h0040, 16'h0004, 16'h0000);
    clk_en = 1'b0;
    @(posedge clk);
    #1;
    chk("freeze", 16'h0000, {15'h0000, rx_ready});
    clk_en = 1'b1;
    run(CMD_NULL, 16'h0040, 16'h0004, 16'h0000);
    tsel = PCMA_PARALLEL_HOST_PORT;
    run(CMD_INTERNAL_READ, 16'h0040, 16'h0004, 16'h0000);
    run(CMD_TRANSPORT_CONFIG, 16'h9abc, 16'h0000, 16'h0000);
    give_verdict();
  end
  // The full sequence needs about 80000 cycles; the limit stays below 100000.
  initial begin
    #950000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
